// File: standby_reset_pkg.sv
/*
  Constants shared by the standby and reset control block.
  Assumes a 100 MHz system clock.
*/
package standby_reset_pkg;

  localparam int unsigned CLK_FREQ_HZ = 100_000_000;

  // Reset input filter: a change counts once it has held this many cycles.
  localparam int unsigned RST_FILTER_NS = 200;
  localparam int unsigned RST_FILTER_CYC =
    (RST_FILTER_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RST_FILTER_W = 8;

  // Oscillation stabilisation wait after leaving the oscillator-stopped mode.
  localparam int unsigned OSC_STAB_US = 1000;
  localparam int unsigned OSC_STAB_CYC =
    (OSC_STAB_US * (CLK_FREQ_HZ / 1_000_000));
  localparam int unsigned OSC_STAB_W = 24;

  // Power-on reset hold that the external source must keep.
  localparam int unsigned PON_HOLD_MS = 40;

  // Byte addresses of the start vector, and the pc value loaded at reset.
  localparam logic [19:0] VEC_LO_ADDR = 20'h00000;
  localparam logic [19:0] VEC_HI_ADDR = 20'h00001;
  localparam logic [19:0] PC_RESET    = 20'h00000;

  // Standby request codes from the CPU core.
  localparam logic [1:0] REQ_HALT = 2'h1;
  localparam logic [1:0] REQ_IDLE = 2'h2;
  localparam logic [1:0] REQ_STOP = 2'h3;

  typedef enum logic [2:0] {
    ST_RESET  = 3'b000,
    ST_VEC_LO = 3'b001,
    ST_VEC_HI = 3'b010,
    ST_RUN    = 3'b011,
    ST_HALT   = 3'b100,
    ST_IDLE   = 3'b101,
    ST_STOP   = 3'b110,
    ST_OSCWT  = 3'b111
  } ctl_state_e;

endpackage : standby_reset_pkg

// File: reset_filter.sv
/*
  Synchroniser and noise filter for the active-low reset pin.
  Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module reset_filter
  import standby_reset_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic reset_pin_n,
  output logic      reset_active
);

  logic                    s1_q, s2_q, s3_q;
  logic                    filt_q, filt_d;
  logic [RST_FILTER_W-1:0] cnt_q, cnt_d;

  // A level differing from the filtered one must hold for the full count.
  always_comb begin
    filt_d = filt_q;
    cnt_d  = '0;
    if ((s2_q == s3_q) && (s3_q != filt_q)) begin
      cnt_d = cnt_q + 1'b1;
      if (cnt_q >= RST_FILTER_W'(RST_FILTER_CYC - 1)) begin
        filt_d = s3_q;
        cnt_d  = '0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      filt_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      s1_q   <= reset_pin_n;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      cnt_q  <= cnt_d;
    end
  end

  assign reset_active = ~filt_q;

endmodule : reset_filter

// File: standby_reset_control.sv
/*
  Standby mode and reset sequence controller.
  Assumes the CPU core requests standby, fetches at fetch_pc on fetch_start,
  and that memory answers on mem_addr within the same cycle.
*/
`timescale 1ns/1ps
module standby_reset_control
  import standby_reset_pkg::*;
#(
  parameter int unsigned OSC_STAB_CYCLES = OSC_STAB_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        reset_pin_n,
  input  wire logic        standby_req,
  input  wire logic [1:0]  standby_mode,
  input  wire logic        irq_unmasked,
  input  wire logic        nmi_ext,
  input  wire logic        nmi_wdt,
  input  wire logic        macro_req,
  input  wire logic        macro_done,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_rd,
  output logic [19:0]      mem_addr,
  output logic             cpu_clk_en,
  output logic             sys_clk_en,
  output logic             osc_en,
  output logic             macro_run,
  output logic             hw_init,
  output logic             fetch_start,
  output logic [19:0]      fetch_pc
);

  logic                  reset_active;
  logic                  wake_ext;
  logic                  wake_any;
  logic                  mac_start;
  logic                  osc_done;

  ctl_state_e            st_q, st_d;
  logic [19:0]           pc_q, pc_d;
  logic                  rd_q, rd_d;
  logic                  fs_q, fs_d;
  logic                  mac_q, mac_d;
  logic [OSC_STAB_W-1:0] wt_q, wt_d;

  reset_filter reset_filter_i (
    .sys_clk      (sys_clk),
    .rst          (rst),
    .reset_pin_n  (reset_pin_n),
    .reset_active (reset_active)
  );

  // The watchdog NMI is deliberately not a release source.
  assign wake_ext = nmi_ext;
  assign wake_any = irq_unmasked || wake_ext;

  // A service request seen in HALT wins over a wake-up in the same cycle,
  // so the core never returns to RUN with a transfer still claimed.
  assign mac_start = (st_q == ST_HALT) && macro_req && !mac_q;
  assign osc_done  = (wt_q >= OSC_STAB_W'(OSC_STAB_CYCLES - 1));

  // Main sequencing: reset, vector fetch, run and the three standby modes.
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_RESET: begin
        if (!reset_active) begin
          st_d = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        st_d = ST_VEC_HI;
      end
      ST_VEC_HI: begin
        st_d = ST_RUN;
      end
      ST_RUN: begin
        if (standby_req) begin
          case (standby_mode)
            REQ_HALT: st_d = ST_HALT;
            REQ_IDLE: st_d = ST_IDLE;
            REQ_STOP: st_d = ST_STOP;
            default:  st_d = ST_RUN;
          endcase
        end
      end
      ST_HALT: begin
        // No wake-up while a service runs or is just being requested.
        if (!mac_q && !macro_req && wake_any) begin
          st_d = ST_RUN;
        end
      end
      ST_IDLE: begin
        if (wake_any) begin
          st_d = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_any) begin
          st_d = ST_OSCWT;
        end
      end
      ST_OSCWT: begin
        if (osc_done) begin
          st_d = ST_RUN;
        end
      end
      default: st_d = ST_RESET;
    endcase
    if (reset_active) begin
      st_d = ST_RESET;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Start vector: two byte reads, then a one-cycle fetch strobe.
  always_comb begin
    pc_d = pc_q;
    rd_d = 1'b0;
    fs_d = 1'b0;
    case (st_q)
      ST_RESET: begin
        pc_d = PC_RESET;
        rd_d = !reset_active;
      end
      ST_VEC_LO: begin
        pc_d = {4'h0, pc_q[15:8], mem_rdata};
        rd_d = 1'b1;
      end
      ST_VEC_HI: begin
        pc_d = {4'h0, mem_rdata, pc_q[7:0]};
        fs_d = 1'b1;
      end
      default: pc_d = pc_q;
    endcase
    // A reset in mid-sequence drops any read or fetch strobe at the next clock edge.
    if (reset_active) begin
      pc_d = PC_RESET;
      rd_d = 1'b0;
      fs_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_q <= PC_RESET;
      rd_q <= 1'b0;
      fs_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      rd_q <= rd_d;
      fs_q <= fs_d;
    end
  end

  // Macro service claim; it is only ever taken from HALT.
  always_comb begin
    mac_d = mac_q;
    if (mac_start) begin
      mac_d = 1'b1;
    end else if (mac_q && macro_done) begin
      mac_d = 1'b0;
    end
    if (reset_active) begin
      mac_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mac_q <= 1'b0;
    end else begin
      mac_q <= mac_d;
    end
  end

  // The stabilisation count runs only in the wait state and restarts at 0.
  always_comb begin
    wt_d = '0;
    if ((st_q == ST_OSCWT) && !reset_active) begin
      wt_d = wt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wt_q <= '0;
    end else begin
      wt_q <= wt_d;
    end
  end

  assign mem_rd      = rd_q;
  assign mem_addr    = (st_q == ST_VEC_HI) ? VEC_HI_ADDR : VEC_LO_ADDR;
  assign cpu_clk_en  = (st_q == ST_RUN);
  assign sys_clk_en  = (st_q != ST_IDLE) && (st_q != ST_STOP)
                       && (st_q != ST_OSCWT);
  assign osc_en      = (st_q != ST_STOP);
  assign macro_run   = mac_q;
  assign hw_init     = (st_q == ST_RESET);
  assign fetch_start = fs_q;
  assign fetch_pc    = pc_q;

endmodule : standby_reset_control

// File: standby_reset_control_assertions.sv
/* Port checks for standby_reset_control; bound in from the bench. */
`timescale 1ns/1ps
module standby_reset_control_assertions
  import standby_reset_pkg::*;
#(parameter int unsigned OSC_STAB_CYCLES = OSC_STAB_CYC) (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reset_pin_n,
  input wire logic        standby_req,
  input wire logic [1:0]  standby_mode,
  input wire logic        irq_unmasked,
  input wire logic        nmi_ext,
  input wire logic        nmi_wdt,
  input wire logic        mem_rd,
  input wire logic [19:0] mem_addr,
  input wire logic        cpu_clk_en,
  input wire logic        sys_clk_en,
  input wire logic        osc_en,
  input wire logic        macro_run,
  input wire logic        hw_init,
  input wire logic        fetch_start
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence lo_s; mem_rd && mem_addr == VEC_LO_ADDR; endsequence
  sequence hi_s; mem_rd && mem_addr == VEC_HI_ADDR; endsequence
  vector_order_a: assert property (lo_s |=> hi_s ##1 fetch_start)
    else $error("vector read order wrong");
  init_hold_a: assert property (hw_init |-> !cpu_clk_en && !mem_rd)
    else $error("activity during reset");
  halt_gate_a: assert property (cpu_clk_en && standby_req
    && standby_mode == REQ_HALT |=> !cpu_clk_en && sys_clk_en && osc_en)
    else $error("halt did not gate only the cpu clock");
  idle_stop_a: assert property (cpu_clk_en && standby_req
    && standby_mode == REQ_IDLE |=> !sys_clk_en && osc_en)
    else $error("idle did not stop the system clocks");
  stop_osc_a: assert property (!osc_en |-> !sys_clk_en)
    else $error("clocks run with oscillator off");
  macro_halt_a: assert property (macro_run |-> !cpu_clk_en)
    else $error("macro service left standby");
  wdt_wake_a: assert property (!osc_en && nmi_wdt && !nmi_ext
    && !irq_unmasked |=> !osc_en) else $error("watchdog woke stop");
  osc_wait_a: assert property ($rose(osc_en) |-> !cpu_clk_en [*8])
    else $error("no oscillator wait");
  noise_a: assert property ($rose(hw_init) |->
    !$past(reset_pin_n, 4) && !$past(reset_pin_n, 24))
    else $error("unfiltered reset");
endmodule : standby_reset_control_assertions

// File: vector_mem_model.sv
/* Memory holding the start vector; answers on mem_addr at once. */
`timescale 1ns/1ps
module vector_mem_model (
  input  wire logic [19:0] mem_addr,
  output logic      [7:0]  mem_rdata
);
  // Other addresses give the inverted low address byte, never a held byte.
  assign mem_rdata = (mem_addr == 20'h00000) ? 8'h34 :
                     (mem_addr == 20'h00001) ? 8'h12 : ~mem_addr[7:0];
endmodule : vector_mem_model

// File: test_standby_reset_control.sv
/* Bench for standby_reset_control; needs vector_mem_model and checker. */
`timescale 1ns/1ps
module test_standby_reset_control;
  import standby_reset_pkg::*;
  logic sys_clk = 0, rst = 1, reset_pin_n = 0, standby_req = 0;
  logic irq_unmasked = 0, nmi_ext = 0, nmi_wdt = 0, macro_req = 0;
  logic macro_done = 0, mem_rd, cpu_clk_en, sys_clk_en, osc_en;
  logic macro_run, hw_init, fetch_start;
  logic [1:0] standby_mode = 0;
  logic [7:0] mem_rdata;
  logic [19:0] mem_addr, fetch_pc;
  int bad_count = 0, num_checks = 0;
  standby_reset_control #(.OSC_STAB_CYCLES(8)) standby_reset_control_i (
    .sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .standby_req(standby_req), .standby_mode(standby_mode),
    .irq_unmasked(irq_unmasked), .nmi_ext(nmi_ext), .nmi_wdt(nmi_wdt),
    .macro_req(macro_req), .macro_done(macro_done),
    .mem_rdata(mem_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .cpu_clk_en(cpu_clk_en), .sys_clk_en(sys_clk_en), .osc_en(osc_en),
    .macro_run(macro_run), .hw_init(hw_init),
    .fetch_start(fetch_start), .fetch_pc(fetch_pc));
  vector_mem_model vector_mem_model_i (
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(logic [19:0] got, logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic wake(int n);
    for (int i = 0; i < n && cpu_clk_en !== 1'b1; i++) cyc(1);
    chk(cpu_clk_en, 1);
  endtask : wake
  task automatic enter(logic [1:0] m, logic [2:0] en);
    standby_mode = m;
    standby_req = 1;
    cyc(1);
    standby_req = 0;
    cyc(3);
    chk({cpu_clk_en, sys_clk_en, osc_en}, en);
  endtask : enter
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic release_pin;
    reset_pin_n = 1;
    for (int i = 0; i < 40 && fetch_start !== 1'b1; i++) cyc(1);
    chk(fetch_start, 1);
    chk(fetch_pc, {4'h0, 8'h12, 8'h34});
  endtask : release_pin
  task automatic power_on;
    cyc(2);
    rst = 0;
    cyc(30);
    chk(hw_init, 1);
    chk(cpu_clk_en, 0);
    release_pin();
  endtask : power_on
  task automatic noise_pulse;
    reset_pin_n = 0;
    cyc(2);
    reset_pin_n = 1;
    cyc(30);
    chk(hw_init, 0);
    chk(cpu_clk_en, 1);
  endtask : noise_pulse
  task automatic halt_macro;
    enter(2'h0, 3'b111);
    enter(REQ_HALT, 3'b011);
    macro_req = 1;
    irq_unmasked = 1;
    cyc(3);
    macro_req = 0;
    chk({macro_run, cpu_clk_en}, 2'b10);
    macro_done = 1;
    cyc(1);
    macro_done = 0;
    wake(10);
    chk(macro_run, 0);
    irq_unmasked = 0;
  endtask : halt_macro
  task automatic idle_wdt;
    enter(REQ_IDLE, 3'b001);
    nmi_wdt = 1;
    cyc(5);
    chk(sys_clk_en, 0);
    nmi_ext = 1;
    wake(10);
    nmi_ext = 0;
    nmi_wdt = 0;
  endtask : idle_wdt
  task automatic stop_wake;
    enter(REQ_STOP, 3'b000);
    nmi_wdt = 1;
    cyc(5);
    chk(osc_en, 0);
    nmi_wdt = 0;
    irq_unmasked = 1;
    cyc(3);
    chk({osc_en, cpu_clk_en}, 2'b10);
    cyc(5);
    chk(cpu_clk_en, 0);
    wake(1);
    irq_unmasked = 0;
  endtask : stop_wake
  task automatic pin_reset;
    reset_pin_n = 0;
    cyc(20);
    chk(hw_init, 0);
    cyc(10);
    chk(hw_init, 1);
    chk({cpu_clk_en, macro_run, fetch_start}, 3'b000);
    release_pin();
  endtask : pin_reset
  initial begin
    power_on();
    noise_pulse();
    halt_macro();
    idle_wdt();
    stop_wake();
    pin_reset();
    complete_run();
  end
  initial begin
    cyc(3000);
    bad_count++;
    complete_run();
  end
endmodule : test_standby_reset_control
bind standby_reset_control standby_reset_control_assertions
  #(.OSC_STAB_CYCLES(OSC_STAB_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rst(rst), .reset_pin_n(reset_pin_n),
  .standby_req(standby_req), .standby_mode(standby_mode),
  .irq_unmasked(irq_unmasked), .nmi_ext(nmi_ext), .nmi_wdt(nmi_wdt),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .cpu_clk_en(cpu_clk_en),
  .sys_clk_en(sys_clk_en), .osc_en(osc_en), .macro_run(macro_run),
  .hw_init(hw_init), .fetch_start(fetch_start));
